// File: shared/grie_consts.svh
// constants for the global reset and interrupt enable register bank
`ifndef GRIE_CONSTS_SVH
`define GRIE_CONSTS_SVH

// ----------------------------------------------------------------
// bus widths
// ----------------------------------------------------------------
`define GRIE_ADDR_W 12
`define GRIE_DATA_W 16
`define GRIE_UNITS 12
`define GRIE_STRAP_W 8

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define GRIE_OFS_SRC 12'h126
`define GRIE_OFS_IEN 12'h190
`define GRIE_OFS_IST 12'h192

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define GRIE_BIT_GSR 0
`define GRIE_BIT_PTP 2
`define GRIE_BIT_MST 3
`define GRIE_BIT_LC 15
`define GRIE_BIT_TS 12
`define GRIE_BIT_TRIG 10

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define GRIE_RST_BIT 1'h0
`define GRIE_RST_DATA 16'h0000
`define GRIE_RST_UNITS 12'h000
`define GRIE_RST_STRAP 8'h00

// ----------------------------------------------------------------
// host timing (soft reset hold before release)
// ----------------------------------------------------------------
`define GRIE_GSR_HOLD_MS 10
`define GRIE_CLK_MHZ 50

`endif

// File: shared/grie_pkg.sv
// types shared by the register bank modules
`default_nettype none
package grie_pkg;
    `include "grie_consts.svh"

    typedef logic [`GRIE_ADDR_W-1:0] grie_addr_t;
    typedef logic [`GRIE_DATA_W-1:0] grie_data_t;
    typedef logic [`GRIE_UNITS-1:0] grie_unit_t;
    typedef logic [`GRIE_STRAP_W-1:0] grie_strap_t;

    // state of one per-unit summary block
    typedef struct packed {
        grie_unit_t st_prev;
        logic summary;
        logic rise;
    } grie_sum_state_t;

    // state of the register bank
    typedef struct packed {
        logic gsr;
        logic ptp;
        logic mst;
        logic ptp_out;
        logic lc_en;
        logic lc_st;
        logic ts_st;
        logic trig_st;
        logic link_prev;
        logic irq;
        grie_data_t rd_data;
        logic strap_done;
        grie_strap_t strap;
    } grie_state_t;
endpackage : grie_pkg
`default_nettype wire

// File: shared/grie_sum_if.sv
// per-unit enable and status summary carrier
`default_nettype none
interface grie_sum_if;
    import grie_pkg::*;
    grie_unit_t en;
    grie_unit_t st;
    logic summary;
    logic rise;
    modport unit (input en, input st, output summary, output rise);
    modport bank (output en, output st, input summary, input rise);
endinterface : grie_sum_if
`default_nettype wire

// File: hdl/grie_summary.sv
// or-summary of per-unit interrupt enables plus status rise detect
`default_nettype none
module grie_summary (
    input wire logic clk, // system clock
    input wire logic rst_n, // synchronised reset, active low
    input wire logic ce, // clock enable
    grie_sum_if.unit sb // per-unit enables and status
);
    import grie_pkg::*;

    grie_sum_state_t s;
    grie_sum_state_t next_s;
    logic st_fall;

    // --------------------------------------------------------
    // summary and rise detection
    // --------------------------------------------------------
    // a cleared status bit drops the summary for one cycle
    always_comb begin
        st_fall = |(s.st_prev & ~sb.st);
        next_s = s;
        next_s.st_prev = sb.st;
        next_s.summary = (|sb.en) & ~st_fall; // R8 R10 R9 R11
        next_s.rise = (|sb.st) & ~(|s.st_prev);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign sb.summary = s.summary;
    assign sb.rise = s.rise;

    // --------------------------------------------------------
    // checks
    // --------------------------------------------------------
    a_sum_or: assert property (@(posedge clk) disable iff (!rst_n) // R8
        ce && !st_fall |=> s.summary == $past(|sb.en))
        else $error("summary is not the or of unit enables");
    a_sum_drop: assert property (@(posedge clk) disable iff (!rst_n) // R9
        ce && st_fall |=> !s.summary)
        else $error("summary kept after a status clear");
endmodule : grie_summary
`default_nettype wire

// File: hdl/grie_top.sv
// global soft reset control and top-level interrupt enable bank
`default_nettype none
`include "grie_consts.svh"

// How it works
// R1 - writing one to bit 3 starts memory self-test, zero stops it
// R2 - bit 2 set holds the whole time subsystem in reset
// R3 - global soft reset returns software registers to defaults
// R4 - strap values latched at power-up survive the soft reset
// R5 - global soft reset bit keeps its written value, no self-clear
// R6 - host holds soft reset at least 10 ms before writing zero
// R7 - enable bit 15 is read/write and gates link change interrupts
// R8 - enable bit 12 reads as or of twelve timestamp unit enables
// R9 - timestamp summary drops when a unit enable or status clears; code drops it only on a status clear
// R10 - enable bit 10 reads as or of twelve trigger unit enables
// R11 - trigger summary drops when a unit enable or status clears; code drops it only on a status clear
// R12 - host writes zeros to the two summary bits
// R13 - interrupt pin high while a status bit and its enable are set
// R14 - link change status is edge set, cleared by writing one
// R15 - soft reset holds logic in reset, reset register stays writable
module grie_top (
    input wire logic ref_clk, // 50 MHz system clock
    input wire logic nrst, // asynchronous reset, active low
    input wire logic ce, // clock enable, freezes state when low
    input wire grie_pkg::grie_addr_t addr, // register address
    input wire grie_pkg::grie_data_t wdata, // write data
    input wire logic wr_en, // write strobe
    input wire logic rd_en, // read strobe
    output var grie_pkg::grie_data_t rd_data, // read data, next cycle
    input wire logic link_up, // link state of the ports
    input wire grie_pkg::grie_unit_t timestamp_unit_irq_enables, // ts ie
    input wire grie_pkg::grie_unit_t timestamp_unit_irq_status, // ts is
    input wire grie_pkg::grie_unit_t trigger_unit_irq_enables, // trig ie
    input wire grie_pkg::grie_unit_t trigger_unit_irq_status, // trig is
    input wire grie_pkg::grie_strap_t strap_in, // strap pin levels
    output logic irq, // level interrupt, active high
    output logic ptp_reset, // time subsystem reset, active high
    output logic memory_self_test_run, // self-test run request
    output logic soft_reset_active, // internal logic held in reset
    output var grie_pkg::grie_strap_t strap_cfg // latched strap values
);
    import grie_pkg::*;

    // --------------------------------------------------------
    // reset release
    // --------------------------------------------------------
    logic [1:0] rst_sync;
    logic rst_s;

    // async assert, two-stage release on the clock
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync <= 2'h0;
        end else if (ce) begin
            rst_sync <= {rst_sync[0], 1'h1};
        end
    end

    assign rst_s = rst_sync[1];

    // --------------------------------------------------------
    // per-unit summaries
    // --------------------------------------------------------
    grie_sum_if ts_if ();
    grie_sum_if trig_if ();

    // unit registers live in the time block; only their bits come here
    assign ts_if.en = timestamp_unit_irq_enables;
    assign ts_if.st = timestamp_unit_irq_status;
    assign trig_if.en = trigger_unit_irq_enables;
    assign trig_if.st = trigger_unit_irq_status;

    grie_summary u_ts_sum (
        .clk (ref_clk),
        .rst_n (rst_s),
        .ce (ce),
        .sb (ts_if)
    );

    grie_summary u_trig_sum (
        .clk (ref_clk),
        .rst_n (rst_s),
        .ce (ce),
        .sb (trig_if)
    );

    // --------------------------------------------------------
    // address decode
    // --------------------------------------------------------
    logic wr_src;
    logic wr_ien;
    logic wr_ist;
    logic rd_src;
    logic rd_ien;
    logic rd_ist;

    always_comb begin
        wr_src = 1'b0;
        wr_ien = 1'b0;
        wr_ist = 1'b0;
        rd_src = 1'b0;
        rd_ien = 1'b0;
        rd_ist = 1'b0;
        if (addr == `GRIE_OFS_SRC) begin
            wr_src = wr_en;
            rd_src = rd_en;
        end else if (addr == `GRIE_OFS_IEN) begin
            wr_ien = wr_en;
            rd_ien = rd_en;
        end else if (addr == `GRIE_OFS_IST) begin
            wr_ist = wr_en;
            rd_ist = rd_en;
        end
    end

    // --------------------------------------------------------
    // register views
    // --------------------------------------------------------
    grie_state_t s;
    grie_state_t next_s;
    grie_data_t src_view;
    grie_data_t ien_view;
    grie_data_t ist_view;

    // reserved bits read as zero
    always_comb begin
        src_view = `GRIE_RST_DATA;
        src_view[`GRIE_BIT_GSR] = s.gsr;
        src_view[`GRIE_BIT_PTP] = s.ptp;
        src_view[`GRIE_BIT_MST] = s.mst;
        ien_view = `GRIE_RST_DATA;
        ien_view[`GRIE_BIT_LC] = s.lc_en;
        ien_view[`GRIE_BIT_TS] = ts_if.summary; // R8
        ien_view[`GRIE_BIT_TRIG] = trig_if.summary; // R10
        ist_view = `GRIE_RST_DATA;
        ist_view[`GRIE_BIT_LC] = s.lc_st;
        ist_view[`GRIE_BIT_TS] = s.ts_st;
        ist_view[`GRIE_BIT_TRIG] = s.trig_st;
    end

    // --------------------------------------------------------
    // next state
    // --------------------------------------------------------
    logic lc_edge;

    always_comb begin
        next_s = s;
        lc_edge = link_up != s.link_prev;
        // edge tracker runs even in soft reset, no false edge on release
        next_s.link_prev = link_up;

        // reset control stays writable at all times
        if (wr_src) begin
            next_s.gsr = wdata[`GRIE_BIT_GSR]; // R5 R15
            next_s.ptp = wdata[`GRIE_BIT_PTP]; // R2
            next_s.mst = wdata[`GRIE_BIT_MST]; // R1
        end

        // enable register: summary bits are read-only, writes dropped
        if (wr_ien) begin
            next_s.lc_en = wdata[`GRIE_BIT_LC]; // R7
        end

        // sticky status, write one clears, a new event wins
        if (wr_ist && wdata[`GRIE_BIT_LC]) begin
            next_s.lc_st = 1'b0;
        end
        if (wr_ist && wdata[`GRIE_BIT_TS]) begin
            next_s.ts_st = 1'b0;
        end
        if (wr_ist && wdata[`GRIE_BIT_TRIG]) begin
            next_s.trig_st = 1'b0;
        end
        if (lc_edge) begin
            next_s.lc_st = 1'b1; // R14
        end
        if (ts_if.rise) begin
            next_s.ts_st = 1'b1;
        end
        if (trig_if.rise) begin
            next_s.trig_st = 1'b1;
        end

        // soft reset: every other software bit back to default
        if (s.gsr) begin
            next_s.ptp = `GRIE_RST_BIT; // R3
            next_s.mst = `GRIE_RST_BIT; // R3
            next_s.lc_en = `GRIE_RST_BIT; // R3
            next_s.lc_st = `GRIE_RST_BIT; // R3
            next_s.ts_st = `GRIE_RST_BIT;
            next_s.trig_st = `GRIE_RST_BIT;
        end

        // strap caught once after the power-on release only
        if (!s.strap_done) begin
            next_s.strap = strap_in; // R4
            next_s.strap_done = 1'b1;
        end

        // time subsystem also held down during a global soft reset
        next_s.ptp_out = next_s.ptp | next_s.gsr; // R2

        // interrupt level from status and enables
        next_s.irq = (next_s.lc_st & next_s.lc_en)
            | (next_s.ts_st & ts_if.summary)
            | (next_s.trig_st & trig_if.summary); // R13

        // read data stands one cycle after the strobe only
        next_s.rd_data = `GRIE_RST_DATA;
        if (rd_src) begin
            next_s.rd_data = src_view;
        end else if (rd_ien) begin
            next_s.rd_data = ien_view;
        end else if (rd_ist) begin
            next_s.rd_data = ist_view;
        end
    end

    // --------------------------------------------------------
    // state register
    // --------------------------------------------------------
    // power-on reset only; soft reset acts through next_s
    always_ff @(posedge ref_clk or negedge rst_s) begin
        if (!rst_s) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    // --------------------------------------------------------
    // outputs
    // --------------------------------------------------------
    assign rd_data = s.rd_data;
    assign irq = s.irq;
    assign ptp_reset = s.ptp_out;
    assign memory_self_test_run = s.mst; // R1
    assign soft_reset_active = s.gsr; // R15
    assign strap_cfg = s.strap;

    // --------------------------------------------------------
    // checks
    // --------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_s);

    a_memory_self_test_start: assert property ( // R1
        ce && wr_src && wdata[`GRIE_BIT_MST] && !s.gsr
        |=> memory_self_test_run)
        else $error("self-test not started by write of one");

    a_memory_self_test_stop: assert property ( // R1
        ce && wr_src && !wdata[`GRIE_BIT_MST]
        |=> !memory_self_test_run)
        else $error("self-test not stopped by write of zero");

    a_ptp_hold: assert property ( // R2
        ce && s.ptp && !s.gsr && !wr_src |=> ptp_reset)
        else $error("time subsystem released while bit 2 set");

    a_ptp_cause: assert property ( // R2
        $rose(ptp_reset) |-> $past(wr_src))
        else $error("time subsystem reset without a write");

    a_soft_clear: assert property ( // R3
        ce && s.gsr |=> !s.lc_en && !s.lc_st && !s.ptp && !s.mst)
        else $error("soft reset left a register off default");

    a_strap_keep: assert property ( // R4
        s.strap_done |=> $stable(strap_cfg))
        else $error("strap values changed after capture");

    a_gsr_sticky: assert property ( // R5
        ce && s.gsr && !wr_src |=> soft_reset_active)
        else $error("soft reset bit cleared by hardware");

    a_lc_enable: assert property ( // R7
        ce && wr_ien && !s.gsr
        |=> s.lc_en == $past(wdata[`GRIE_BIT_LC]))
        else $error("link change enable did not take write");

    // a unit rise or an enable write in the same cycle may raise the pin
    a_lc_gate: assert property ( // R7
        ce && !s.lc_en && !wr_ien && !s.ts_st && !s.trig_st
        && !ts_if.rise && !trig_if.rise |=> !irq)
        else $error("interrupt raised with all sources blocked");

    a_irq_level: assert property ( // R13
        ce && !s.gsr && s.lc_st && s.lc_en
        && !(wr_ist && wdata[`GRIE_BIT_LC]) && !wr_ien |=> irq)
        else $error("interrupt low with enabled status set");

    a_lc_edge: assert property ( // R14
        ce && !s.gsr && (link_up != s.link_prev) |=> s.lc_st)
        else $error("link edge not recorded");

    a_lc_sticky: assert property ( // R14
        ce && !s.gsr && s.lc_st && !(wr_ist && wdata[`GRIE_BIT_LC])
        ##1 ce && !s.gsr && !(wr_ist && wdata[`GRIE_BIT_LC])
        |=> s.lc_st)
        else $error("link status lost without a clear");

    a_src_release: assert property ( // R15
        ce && wr_src && s.gsr && !wdata[`GRIE_BIT_GSR]
        |=> !soft_reset_active)
        else $error("soft reset could not be released");

    a_read_slot: assert property (
        ce && !rd_en |=> rd_data == `GRIE_RST_DATA)
        else $error("read data outside its slot");

    // unit sources use their summary as the mask
    a_trig_irq: assert property ( // R13
        ce && !s.gsr && s.trig_st && trig_if.summary
        && !(wr_ist && wdata[`GRIE_BIT_TRIG]) |=> irq)
        else $error("interrupt low with trigger status enabled");

    a_ts_irq: assert property ( // R13
        ce && !s.gsr && s.ts_st && ts_if.summary
        && !(wr_ist && wdata[`GRIE_BIT_TS]) |=> irq)
        else $error("interrupt low with timestamp status enabled");

    a_lc_clear: assert property ( // R14
        ce && !s.gsr && wr_ist && wdata[`GRIE_BIT_LC] && !lc_edge
        |=> !s.lc_st)
        else $error("link status not cleared by a one");

    a_ptp_soft: assert property ( // R2
        ce && s.gsr && !wr_src |=> ptp_reset)
        else $error("time subsystem released during soft reset");

    a_strap_take: assert property ( // R4
        ce && !s.strap_done |=> strap_cfg == $past(strap_in))
        else $error("strap values not captured at release");

    // covers for the main scenarios
    c_soft_reset: cover property (
        ce && wr_src && wdata[`GRIE_BIT_GSR]
        ##[1:20] ce && wr_src && !wdata[`GRIE_BIT_GSR]);
    c_lc_irq: cover property (ce && s.lc_en && lc_edge ##2 irq);
    c_lc_clear: cover property (
        s.lc_st ##1 ce && wr_ist && wdata[`GRIE_BIT_LC] ##1 !s.lc_st);
    c_ts_read: cover property (ce && rd_ien && ts_if.summary);
    c_trig_irq: cover property (ce && trig_if.rise ##1 irq);
endmodule : grie_top
`default_nettype wire

// File: testbench/test_grie_top.sv
// self-checking bench for the reset control and interrupt enable bank
`default_nettype none
`include "grie_consts.svh"

// ----------------------------------------------------------------
// compare helper
// ----------------------------------------------------------------
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin \
    n_errors++; $display("FAIL t=%0t got=%h exp=%h", $time, got, exp); \
    end end

module test_grie_top;
    timeunit 1ns;
    timeprecision 1ps;
    import grie_pkg::*;

    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    grie_addr_t addr = '0;
    grie_data_t wdata = '0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    grie_data_t rd_data;
    logic link_up = 1'b0;
    grie_unit_t ts_en = '0;
    grie_unit_t ts_st = '0;
    grie_unit_t tr_en = '0;
    grie_unit_t tr_st = '0;
    grie_strap_t strap_in = 8'hA5;
    logic irq;
    logic ptp_reset;
    logic memory_self_test_run;
    logic soft_reset_active;
    grie_strap_t strap_cfg;
    int n_errors = 0;
    int compares = 0;
    int cycles = 0;
    int zeros;

    grie_top grie_top_inst (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .ce(ce),
        .addr(addr),
        .wdata(wdata),
        .wr_en(wr_en),
        .rd_en(rd_en),
        .rd_data(rd_data),
        .link_up(link_up),
        .timestamp_unit_irq_enables(ts_en),
        .timestamp_unit_irq_status(ts_st),
        .trigger_unit_irq_enables(tr_en),
        .trigger_unit_irq_status(tr_st),
        .strap_in(strap_in),
        .irq(irq),
        .ptp_reset(ptp_reset),
        .memory_self_test_run(memory_self_test_run),
        .soft_reset_active(soft_reset_active),
        .strap_cfg(strap_cfg)
    );

    // ----------------------------------------------------------------
    // clock and hang guard
    // ----------------------------------------------------------------
    always #10 ref_clk = ~ref_clk;

    // the whole run needs well under a thousand cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            end_of_test();
        end
    end

    // ----------------------------------------------------------------
    // bus tasks
    // ----------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick

    // one-cycle write strobe; effect visible right after the taking edge
    task automatic wr(input grie_addr_t a, input grie_data_t d);
        @(posedge ref_clk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr_en <= 1'b0;
        #1;
    endtask : wr

    // read data stands only in the cycle after the strobe
    task automatic rd(input grie_addr_t a, output grie_data_t d);
        @(posedge ref_clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1;
        d = rd_data;
    endtask : rd

    task automatic rchk(input grie_addr_t a, input grie_data_t exp);
        grie_data_t d;
        rd(a, d);
        `CHK(d, exp)
    endtask : rchk

    task automatic end_of_test();
        $display("errors=%0d compares=%0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        tick(4);
        nrst <= 1'b1;
        tick(4);
        // defaults, unmapped address, strap values captured at release
        rchk(`GRIE_OFS_SRC, 16'h0000);
        rchk(`GRIE_OFS_IEN, 16'h0000);
        rchk(12'h100, 16'h0000);
        `CHK(strap_cfg, 8'hA5)
        // a frozen clock enable must swallow the write
        ce <= 1'b0;
        wr(`GRIE_OFS_SRC, 16'h0008);
        tick(1);
        `CHK(memory_self_test_run, 1'b0)
        ce <= 1'b1;
        // self-test start and stop, reserved bits read back as zero
        wr(`GRIE_OFS_SRC, 16'hFFF8);
        `CHK(memory_self_test_run, 1'b1)
        `CHK(ptp_reset, 1'b0)
        rchk(`GRIE_OFS_SRC, 16'h0008);
        tick(1);
        `CHK(rd_data, 16'h0000)
        wr(`GRIE_OFS_SRC, 16'h0004);
        `CHK(memory_self_test_run, 1'b0)
        `CHK(ptp_reset, 1'b1)
        rchk(`GRIE_OFS_SRC, 16'h0004);
        wr(`GRIE_OFS_SRC, 16'h0000);
        `CHK(ptp_reset, 1'b0)
        // summaries follow the or of the unit enables, any position
        ts_en <= 12'h800;
        tick(3);
        rchk(`GRIE_OFS_IEN, 16'h1000);
        ts_en <= 12'h001;
        tick(3);
        rchk(`GRIE_OFS_IEN, 16'h1000);
        ts_en <= 12'h000;
        tick(3);
        rchk(`GRIE_OFS_IEN, 16'h0000);
        tr_en <= 12'h400;
        tick(3);
        rchk(`GRIE_OFS_IEN, 16'h0400);
        // link change enable is plain read/write
        wr(`GRIE_OFS_IEN, 16'h8000);
        rchk(`GRIE_OFS_IEN, 16'h8400);
        tr_en <= 12'h000;
        tick(3);
        rchk(`GRIE_OFS_IEN, 16'h8000);
        // link change: sticky, not cleared by reading, cleared by a one
        @(posedge ref_clk);
        link_up <= 1'b1;
        tick(2);
        `CHK(irq, 1'b1)
        rchk(`GRIE_OFS_IST, 16'h8000);
        rchk(`GRIE_OFS_IST, 16'h8000);
        wr(`GRIE_OFS_IST, 16'h8000);
        tick(1);
        `CHK(irq, 1'b0)
        rchk(`GRIE_OFS_IST, 16'h0000);
        // event with the enable off is recorded but kept off the pin
        wr(`GRIE_OFS_IEN, 16'h0000);
        @(posedge ref_clk);
        link_up <= 1'b0;
        tick(3);
        `CHK(irq, 1'b0)
        rchk(`GRIE_OFS_IST, 16'h8000);
        wr(`GRIE_OFS_IST, 16'h8000);
        // trigger unit event raises the pin through its summary
        tr_en <= 12'h001;
        tick(3);
        @(posedge ref_clk);
        tr_st <= 12'h001;
        tick(5);
        `CHK(irq, 1'b1)
        rchk(`GRIE_OFS_IST, 16'h0400);
        // a falling unit status must knock the summary down briefly
        @(posedge ref_clk);
        tr_st <= 12'h000;
        rd_en <= 1'b1;
        addr <= `GRIE_OFS_IEN;
        zeros = 0;
        repeat (4) begin
            @(posedge ref_clk);
            #1;
            if (rd_data[`GRIE_BIT_TRIG] === 1'b0) zeros++;
        end
        rd_en <= 1'b0;
        `CHK(zeros > 0, 1'b1)
        `CHK(rd_data, 16'h0400)
        wr(`GRIE_OFS_IST, 16'h0400);
        tick(1);
        `CHK(irq, 1'b0)
        // timestamp unit event raises the pin the same way
        tr_en <= 12'h000;
        ts_en <= 12'h002;
        tick(3);
        @(posedge ref_clk);
        ts_st <= 12'h002;
        tick(5);
        `CHK(irq, 1'b1)
        rchk(`GRIE_OFS_IST, 16'h1000);
        wr(`GRIE_OFS_IST, 16'h1000);
        tick(1);
        `CHK(irq, 1'b0)
        // unit enables live outside the bank, so drop them before reset
        ts_en <= 12'h000;
        ts_st <= 12'h000;
        tick(3);
        // global soft reset: defaults back, straps kept, bit stays set
        wr(`GRIE_OFS_IEN, 16'h8000);
        wr(`GRIE_OFS_SRC, 16'h0008);
        strap_in <= 8'h3C;
        // self-test bit written high with it, so the soft reset must clear it
        wr(`GRIE_OFS_SRC, 16'h0009);
        tick(50);
        `CHK(soft_reset_active, 1'b1)
        `CHK(ptp_reset, 1'b1)
        `CHK(memory_self_test_run, 1'b0)
        `CHK(strap_cfg, 8'hA5)
        rchk(`GRIE_OFS_SRC, 16'h0001);
        rchk(`GRIE_OFS_IEN, 16'h0000);
        wr(`GRIE_OFS_IEN, 16'h8000);
        tick(1);
        rchk(`GRIE_OFS_IEN, 16'h0000);
        // events while held are dropped
        @(posedge ref_clk);
        link_up <= 1'b1;
        tick(3);
        rchk(`GRIE_OFS_IST, 16'h0000);
        // the reset control register stays writable for the release
        // hold kept short to fit the run; the bank does not time it
        wr(`GRIE_OFS_SRC, 16'h0000);
        tick(1);
        `CHK(soft_reset_active, 1'b0)
        `CHK(ptp_reset, 1'b0)
        `CHK(irq, 1'b0)
        `CHK(strap_cfg, 8'hA5)
        end_of_test();
    end
endmodule : test_grie_top
`undef CHK
`default_nettype wire
